// ### rtl/headphone_amp_mode_control.sv
// headphone amplifier mode and control logic behind an apb register bank
// assumes apb signals synchronous to SYS_CLK; analog blocks sit outside

`timescale 1ns/100ps

module headphone_amp_mode_control (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HW_SHUTDOWN_N,
    input wire logic THERMAL_FAULT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [hp_mode_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic CHARGE_PUMP_ON,
    output logic LEFT_AMP_ON,
    output logic RIGHT_AMP_ON,
    output logic LEFT_FLOAT,
    output logic RIGHT_FLOAT,
    output logic LEFT_MUTE,
    output logic RIGHT_MUTE,
    output logic [5:0] LEFT_VOLUME,
    output logic [5:0] RIGHT_VOLUME,
    output logic LEFT_FROM_LEFT_IN,
    output logic RIGHT_FROM_LEFT_IN,
    output logic BRIDGE_ON,
    output logic DEVICE_ACTIVE
);
    import hp_mode_pkg::*;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] volume;
        logic [7:0] floater;
        logic thermal_log;
        logic [31:0] rdata;
        logic charge_pump;
        logic left_amp;
        logic right_amp;
        logic left_float;
        logic right_float;
        logic left_mute;
        logic right_mute;
        logic [5:0] left_vol;
        logic [5:0] right_vol;
        logic left_src_left;
        logic right_src_left;
        logic bridge;
        logic active;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    logic access;
    logic wr;
    logic hw_off;
    logic [7:0] wbyte;
    logic mapped;

    assign access = PSEL & PENABLE;
    assign wr = access & PWRITE;
    assign wbyte = PWDATA[7:0];
    assign mapped = (PADDR == OFS_CONTROL) || (PADDR == OFS_VOLUME) ||
        (PADDR == OFS_FLOAT);
    // shutdown pin wins over everything except RST, including register writes
    assign hw_off = ~HW_SHUTDOWN_N;

    always_comb begin
        logic pd;
        logic both_en;
        logic [1:0] mode;
        nxt_ff = cur_ff;
        pd = 1'b0;
        both_en = 1'b0;
        mode = MODE_STEREO;

        if (wr && PADDR == OFS_CONTROL) begin
            // thermal bit is status only; host writes never touch it
            nxt_ff.control = wbyte;
            nxt_ff.control[CTL_THERMAL] = cur_ff.control[CTL_THERMAL];
            if (wbyte[CTL_POWERDOWN]) begin
                nxt_ff.control[CTL_LEFT_EN] = 1'b0;
                nxt_ff.control[CTL_RIGHT_EN] = 1'b0;
            end
        end
        if (wr && PADDR == OFS_VOLUME) begin
            nxt_ff.volume = wbyte;
        end
        if (wr && PADDR == OFS_FLOAT) begin
            nxt_ff.floater = {6'h00, wbyte[FLT_RIGHT:FLT_LEFT]};
        end

        // fault log sets and holds; set wins over any write
        if (THERMAL_FAULT) begin
            nxt_ff.thermal_log = 1'b1;
            nxt_ff.control[CTL_THERMAL] = 1'b1;
        end

        if (access) begin
            unique case (PADDR)
                OFS_CONTROL: nxt_ff.rdata = {24'h000000, cur_ff.control};
                OFS_VOLUME: nxt_ff.rdata = {24'h000000, cur_ff.volume};
                OFS_FLOAT: nxt_ff.rdata = {24'h000000, cur_ff.floater};
                default: nxt_ff.rdata = 32'h00000000;
            endcase
        end

        pd = nxt_ff.control[CTL_POWERDOWN];
        mode = nxt_ff.control[CTL_MODE_HI:CTL_MODE_LO];
        both_en = nxt_ff.control[CTL_LEFT_EN] & nxt_ff.control[CTL_RIGHT_EN];

        // thermal fault holds the amplifiers and pump off while present
        nxt_ff.active = ~pd & ~THERMAL_FAULT;
        nxt_ff.charge_pump = ~pd & ~THERMAL_FAULT;
        nxt_ff.left_amp = nxt_ff.active & nxt_ff.control[CTL_LEFT_EN];
        nxt_ff.right_amp = nxt_ff.active &
            nxt_ff.control[CTL_RIGHT_EN];
        // float only honoured while active with amps off; else outputs idle
        nxt_ff.left_float = nxt_ff.active & ~nxt_ff.left_amp &
            nxt_ff.floater[FLT_LEFT];
        nxt_ff.right_float = nxt_ff.active & ~nxt_ff.right_amp &
            nxt_ff.floater[FLT_RIGHT];
        nxt_ff.left_mute = nxt_ff.volume[VOL_MUTE_L];
        nxt_ff.right_mute = nxt_ff.volume[VOL_MUTE_R];
        nxt_ff.left_vol = nxt_ff.volume[VOL_W-1:0];
        nxt_ff.right_vol = nxt_ff.volume[VOL_W-1:0];

        nxt_ff.left_src_left = 1'b1;
        nxt_ff.right_src_left = 1'b0;
        nxt_ff.bridge = 1'b0;
        if (both_en) begin
            unique case (mode)
                MODE_STEREO: nxt_ff.right_src_left = 1'b0;
                MODE_DUAL_MONO: nxt_ff.right_src_left = 1'b1;
                MODE_BRIDGE: begin
                    nxt_ff.right_src_left = 1'b1;
                    nxt_ff.bridge = 1'b1;
                end
                // reserved code falls back to plain stereo routing
                MODE_RESERVED: nxt_ff.right_src_left = 1'b0;
            endcase
        end

        if (hw_off) begin
            nxt_ff = '0;
            nxt_ff.control = CONTROL_RST;
            nxt_ff.volume = VOLUME_RST;
            nxt_ff.floater = FLOAT_RST;
            nxt_ff.left_mute = 1'b1;
            nxt_ff.right_mute = 1'b1;
            nxt_ff.left_src_left = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            // defaults: pump on, amps off, no float, stereo, muted, min vol
            cur_ff <= '0;
            cur_ff.control <= CONTROL_RST;
            cur_ff.volume <= VOLUME_RST;
            cur_ff.floater <= FLOAT_RST;
            cur_ff.charge_pump <= 1'b1;
            cur_ff.active <= 1'b1;
            cur_ff.left_mute <= 1'b1;
            cur_ff.right_mute <= 1'b1;
            cur_ff.left_src_left <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // zero-wait slave: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = access & ~mapped;
    assign PRDATA = cur_ff.rdata;
    assign CHARGE_PUMP_ON = cur_ff.charge_pump;
    assign LEFT_AMP_ON = cur_ff.left_amp;
    assign RIGHT_AMP_ON = cur_ff.right_amp;
    assign LEFT_FLOAT = cur_ff.left_float;
    assign RIGHT_FLOAT = cur_ff.right_float;
    assign LEFT_MUTE = cur_ff.left_mute;
    assign RIGHT_MUTE = cur_ff.right_mute;
    assign LEFT_VOLUME = cur_ff.left_vol;
    assign RIGHT_VOLUME = cur_ff.right_vol;
    assign LEFT_FROM_LEFT_IN = cur_ff.left_src_left;
    assign RIGHT_FROM_LEFT_IN = cur_ff.right_src_left;
    assign BRIDGE_ON = cur_ff.bridge;
    assign DEVICE_ACTIVE = cur_ff.active;
endmodule : headphone_amp_mode_control

// ### rtl/hp_mode_pkg.sv
// constants for the headphone amplifier mode and control register bank
// assumes an apb master with 32-bit data and one aligned word per register
package hp_mode_pkg;
    localparam int ADDR_W = 4;
    // register offsets, byte addresses (index times four)
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_VOLUME = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_FLOAT = 4'hc;
    // control register fields
    localparam int CTL_RIGHT_EN = 7;
    localparam int CTL_LEFT_EN = 6;
    localparam int CTL_MODE_HI = 5;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_THERMAL = 1;
    localparam int CTL_POWERDOWN = 0;
    // volume register fields
    localparam int VOL_MUTE_R = 7;
    localparam int VOL_MUTE_L = 6;
    localparam int VOL_W = 6;
    // float register fields
    localparam int FLT_RIGHT = 1;
    localparam int FLT_LEFT = 0;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] VOLUME_RST = 8'hc0;
    localparam logic [7:0] FLOAT_RST = 8'h00;
    // output mode encodings
    localparam logic [1:0] MODE_STEREO = 2'h0;
    localparam logic [1:0] MODE_DUAL_MONO = 2'h1;
    localparam logic [1:0] MODE_BRIDGE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
endpackage : hp_mode_pkg

// ### dv/hp_apb_host.sv
// apb master standing in for the host processor
// assumes one clock; the bench calls xfer hierarchically
`timescale 1ns/100ps
module hp_apb_host (
    input wire logic clk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [3:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d; // whole word every time
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk); while (!pready && ++n < 64);
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show garbage, not the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : hp_apb_host

// ### dv/hp_mode_checker.sv
// port assertions for the mode control block
// assumes it is bound onto headphone_amp_mode_control
`timescale 1ns/100ps
module hp_mode_checker
    import hp_mode_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HW_SHUTDOWN_N,
    input wire logic THERMAL_FAULT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic CHARGE_PUMP_ON,
    input wire logic LEFT_AMP_ON,
    input wire logic RIGHT_AMP_ON,
    input wire logic LEFT_FLOAT,
    input wire logic LEFT_MUTE,
    input wire logic RIGHT_MUTE,
    input wire logic [5:0] LEFT_VOLUME,
    input wire logic RIGHT_FROM_LEFT_IN,
    input wire logic BRIDGE_ON,
    input wire logic DEVICE_ACTIVE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire logic wr_ctl = PSEL && PENABLE && PWRITE && PADDR == OFS_CONTROL
        && HW_SHUTDOWN_N && !THERMAL_FAULT;
    a_hw_dark: assert property (!HW_SHUTDOWN_N |=>
        !CHARGE_PUMP_ON && !DEVICE_ACTIVE && !LEFT_AMP_ON && !RIGHT_AMP_ON)
        else $error("block live during hw shutdown");
    a_hw_defaults: assert property (!HW_SHUTDOWN_N |=>
        LEFT_MUTE && RIGHT_MUTE && LEFT_VOLUME == 6'h00)
        else $error("defaults not restored in hw shutdown");
    a_sw_down: assert property (wr_ctl && PWDATA[0] |=>
        !CHARGE_PUMP_ON && !LEFT_AMP_ON && !RIGHT_AMP_ON)
        else $error("power-down write left pump or amps on");
    a_sw_wake: assert property (wr_ctl && !PWDATA[0] |=> CHARGE_PUMP_ON)
        else $error("pump off after wake write");
    a_amp_enable: assert property (wr_ctl && !PWDATA[0] |=>
        LEFT_AMP_ON == $past(PWDATA[6]) && RIGHT_AMP_ON == $past(PWDATA[7]))
        else $error("amp enables do not follow write");
    a_pump_idle: assert property (DEVICE_ACTIVE |-> CHARGE_PUMP_ON)
        else $error("pump off while active");
    a_float_safe: assert property (LEFT_FLOAT |->
        DEVICE_ACTIVE && !LEFT_AMP_ON) else $error("float while amp live");
    a_bridge_route: assert property (wr_ctl && PWDATA[7:6] == 2'b11
        && !PWDATA[0] |=> BRIDGE_ON == ($past(PWDATA[5:4]) == MODE_BRIDGE)
        && RIGHT_FROM_LEFT_IN == ($past(PWDATA[5:4]) inside {2'h1, 2'h2}))
        else $error("mode routing wrong");
    a_thermal_off: assert property (THERMAL_FAULT |=>
        !DEVICE_ACTIVE && !CHARGE_PUMP_ON) else $error("live in fault");
    c_sw_down: cover property (wr_ctl && PWDATA[0]);
    c_bridge: cover property (BRIDGE_ON);
    c_float: cover property (LEFT_FLOAT);
endmodule : hp_mode_checker
bind headphone_amp_mode_control hp_mode_checker u_chk (.*);

// ### dv/headphone_amp_mode_control_bench.sv
// self-checking bench: host model drives apb, reads checked via queue
// assumes the checker is bound onto the design
`timescale 1ns/100ps
module headphone_amp_mode_control_bench;
    import hp_mode_pkg::*;
    logic clk = 0, rst = 1, sd_n = 1, therm = 0, rd_due = 0;
    logic psel, penable, pwrite, pready, pslverr, pump, act, lamp, ramp;
    logic lflt, rflt, lmute, rmute, lfl, rfl, bridge;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] lvol, rvol;
    logic [31:0] exp_q[$];
    int fail_count = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    hp_apb_host u_host (.clk(clk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    headphone_amp_mode_control u_dut (.SYS_CLK(clk), .RST(rst),
        .HW_SHUTDOWN_N(sd_n), .THERMAL_FAULT(therm), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CHARGE_PUMP_ON(pump), .LEFT_AMP_ON(lamp), .RIGHT_AMP_ON(ramp),
        .LEFT_FLOAT(lflt), .RIGHT_FLOAT(rflt), .LEFT_MUTE(lmute),
        .RIGHT_MUTE(rmute), .LEFT_VOLUME(lvol), .RIGHT_VOLUME(rvol),
        .LEFT_FROM_LEFT_IN(lfl), .RIGHT_FROM_LEFT_IN(rfl),
        .BRIDGE_ON(bridge), .DEVICE_ACTIVE(act));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        u_host.xfer(1'b0, a, 32'h0);
    endtask : rd
    // packed as pump, active, amps l/r, floats l/r, bridge, right-from-left
    task automatic outs(input logic [7:0] e);
        @(posedge clk);
        #1;
        chk({24'h0, pump, act, lamp, ramp, lflt, rflt, bridge, rfl}, e);
    endtask : outs
    // read data is registered, so it is taken one edge after completion
    always @(posedge clk) begin
        if (rd_due && exp_q.size() > 0) chk(prdata, exp_q.pop_front());
        // unmapped offsets must flag an error in the access phase
        if (psel && penable) chk({31'h0, pslverr},
            {31'h0, !(paddr inside {OFS_CONTROL, OFS_VOLUME, OFS_FLOAT})});
        rd_due <= psel && penable && !pwrite && pready;
    end
    initial begin
        #100us;
        fail_count++;
        test_done();
    end
    initial begin
        logic [7:0] v;
        void'($urandom(58));
        v = 8'($urandom) & 8'h3f;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CONTROL, CONTROL_RST);
        rd(OFS_VOLUME, VOLUME_RST);
        rd(OFS_FLOAT, FLOAT_RST);
        outs(8'hc0);
        chk({31'h0, lfl}, 32'h1);
        wr(OFS_VOLUME, v);
        rd(OFS_VOLUME, v);
        chk({24'h0, rmute, lmute, lvol}, {24'h0, v});
        chk({26'h0, rvol}, {26'h0, v[5:0]});
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CONTROL, {2'b11, m[1:0], 4'h0});
            rd(OFS_CONTROL, {2'b11, m[1:0], 4'h0});
            outs({6'b111100, m == 2, m == 1 || m == 2});
        end
        wr(OFS_CONTROL, 8'hc1);
        rd(OFS_CONTROL, 8'h01);
        rd(OFS_VOLUME, v);
        outs(8'h00);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_FLOAT, 8'h03); // active with amps off
        outs(8'hcc);
        wr(OFS_FLOAT, 8'h00);
        therm <= 1'b1;
        outs(8'h00);
        @(posedge clk);
        therm <= 1'b0;
        rd(OFS_CONTROL, 8'h02);
        wr(OFS_CONTROL, 8'hc0);
        sd_n <= 1'b0;
        outs(8'h00);
        wr(OFS_VOLUME, 8'h15);
        sd_n <= 1'b1;
        rd(OFS_CONTROL, CONTROL_RST);
        rd(OFS_VOLUME, VOLUME_RST);
        rd(4'h0, 8'h00);
        repeat (3) @(posedge clk);
        test_done();
    end
endmodule : headphone_amp_mode_control_bench
